// ===== logic/tcr_pkg.sv
`default_nettype none
package tcr_pkg;
    // ********************************************************
    // Clock and timing.
    // ********************************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_US = 100;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int SEC_US = 1_000_000;
    localparam int TICKS_PER_SEC = SEC_US / TICK_US;
    localparam int ZERO_US = 2000;
    localparam int ONE_US = 5000;
    localparam int MARK_US = 8000;
    localparam int PRESENT_US = 30000;
    localparam int W_MIN = ZERO_US / 2 / TICK_US;
    localparam int ZERO_MAX = (ZERO_US + ONE_US) / 2 / TICK_US;
    localparam int ONE_MAX = (ONE_US + MARK_US) / 2 / TICK_US;
    localparam int MARK_MAX = (MARK_US + 10000) / 2 / TICK_US;
    localparam int PRESENT_TICKS = PRESENT_US / TICK_US;
    // ********************************************************
    // Frame layout (bit positions within one frame).
    // ********************************************************
    localparam int FRAME_LEN = 100;
    localparam int P_SEC = 1;
    localparam int P_MIN = 10;
    localparam int P_HOUR = 20;
    localparam int P_DAY = 30;
    localparam int P_YEAR = 50;
    localparam int P_CF = 60;
    localparam int P_CF_END = 78;
    localparam int P_DST = 63;
    localparam int P_OFF_SIGN = 64;
    localparam int P_OFF = 65;
    localparam int P_PARITY = 75;
    localparam int P_SBS = 80;
    localparam int P_SBS_END = 97;
    // ********************************************************
    // Registers.
    // ********************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_YEAR = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TIME = 8'h0C;
    localparam logic [7:0] ADDR_HOURS = 8'h10;
    localparam logic [7:0] ADDR_LOSS = 8'h14;
    localparam int F_EN = 0;
    localparam int F_CONV = 1;
    localparam int F_PRIO = 4;
    localparam int F_DST = 7;
    localparam int F_TZ = 8;
    localparam int F_TMO = 16;
    localparam logic [2:0] PRIO_RST = 3'h1;
    localparam logic [2:0] PRIO_MAX = 3'h5;
    localparam logic [11:0] TMO_RST = 12'h014;
    localparam logic [11:0] TMO_MAX = 12'hE10;
    localparam logic [7:0] YEAR_RST = 8'h00;

    typedef enum logic [1:0] {
        CONV_UTC,
        CONV_LOCAL_STD,
        CONV_LOCAL_DST,
        CONV_EXTENDED
    } tcr_conv_e;

    typedef struct packed {
        logic enable;
        tcr_conv_e conv;
        logic [2:0] prio;
        logic dst;
        logic signed [4:0] tz;
        logic [11:0] timeout;
    } tcr_ctrl_s;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [11:0] day;
        logic [7:0] year;
    } tcr_time_s;
endpackage
`default_nettype wire

// ===== logic/tcr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== logic/tcr_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_tick_div #(
    parameter int DIV = 4000
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Count enable in, one-cycle tick out.
    input wire logic en,
    output logic tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_q;
    wire wrap = en && (cnt_q == LAST);

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= wrap;
            if (wrap)
                cnt_q <= '0;
            else if (en)
                cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== logic/tcr_receiver.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_receiver #(
    parameter int TICK_CYC = tcr_pkg::TICK_CYC,
    parameter int TICKS_PER_SEC = tcr_pkg::TICKS_PER_SEC
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // APB slave.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Time code line and second pulse.
    input wire logic code_in,
    input wire logic pps_in,
    // Best priority of other available sources, 0 when none.
    input wire logic [2:0] other_prio,
    // Status and time towards the device clock.
    output logic code_present_flag,
    output logic frame_decoded_flag,
    output logic [2:0] variant_received,
    output logic extended_format_compliant,
    output logic sync_enabled,
    output logic locked,
    output logic sync_pulse,
    output tcr_pkg::tcr_time_s time_out,
    output logic [4:0] utc_hour,
    output logic [4:0] local_hour
);
    // ********************************************************
    // Input synchronisers and time base.
    // ********************************************************
    logic code_s, pps_s, tick, sec_tick;

    tcr_sync #(.W(2)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .async_in({code_in, pps_in}),
        .sync_out({code_s, pps_s})
    );

    tcr_tick_div #(.DIV(TICK_CYC)) u_tick (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .en(1'b1),
        .tick(tick)
    );

    tcr_tick_div #(.DIV(TICKS_PER_SEC)) u_sec (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .en(tick),
        .tick(sec_tick)
    );

    // ********************************************************
    // Pulse width measurement and symbol classification.
    // ********************************************************
    logic code_d_q, pps_d_q;
    logic [6:0] hi_cnt_q;
    logic [8:0] idle_q;
    wire code_fall = code_d_q && !code_s;
    wire pps_rise = pps_s && !pps_d_q;
    wire w_bad = (hi_cnt_q < 7'(tcr_pkg::W_MIN))
        || (hi_cnt_q > 7'(tcr_pkg::MARK_MAX));
    wire w_one = (hi_cnt_q > 7'(tcr_pkg::ZERO_MAX))
        && (hi_cnt_q <= 7'(tcr_pkg::ONE_MAX));
    wire w_mark = (hi_cnt_q > 7'(tcr_pkg::ONE_MAX)) && !w_bad;
    wire sym_ok = code_fall && !w_bad;

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            code_d_q <= 1'b0;
            pps_d_q <= 1'b0;
            hi_cnt_q <= '0;
        end
        else
        begin
            code_d_q <= code_s;
            pps_d_q <= pps_s;
            if (!code_s)
                hi_cnt_q <= '0;
            else if (tick && hi_cnt_q != 7'h7F)
                hi_cnt_q <= hi_cnt_q + 1'b1;
        end
    end

    // Presence is judged on well-formed pulses, so line noise that
    // merely toggles the input does not count as a signal.
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            idle_q <= 9'(tcr_pkg::PRESENT_TICKS);
        else if (sym_ok)
            idle_q <= '0;
        else if (tick && idle_q != 9'(tcr_pkg::PRESENT_TICKS))
            idle_q <= idle_q + 1'b1;
    end

    assign code_present_flag =
        (idle_q != 9'(tcr_pkg::PRESENT_TICKS));

    // ********************************************************
    // Frame alignment.
    // ********************************************************
    typedef enum logic {ST_HUNT, ST_COLLECT} tcr_state_e;
    tcr_state_e st_q;
    logic prev_mark_q, done_q;
    logic [6:0] idx_q;
    logic [3:0] unit_q;
    logic [tcr_pkg::FRAME_LEN-1:0] bits_q;
    wire expect_mark = (unit_q == 4'h9) || (idx_q == 7'h00);
    wire last_pos = (idx_q == 7'(tcr_pkg::FRAME_LEN - 1));

    // A marker pair is the reference point; any symbol out of place
    // sends the aligner back to hunting so a torn frame never decodes.
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            st_q <= ST_HUNT;
            prev_mark_q <= 1'b0;
            idx_q <= '0;
            unit_q <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (code_fall)
                prev_mark_q <= w_mark;
            if (!code_present_flag)
                st_q <= ST_HUNT;
            else if (code_fall)
            begin
                unique case (st_q)
                    ST_HUNT:
                    begin
                        if (w_mark && prev_mark_q)
                        begin
                            st_q <= ST_COLLECT;
                            idx_q <= 7'h01;
                            unit_q <= 4'h1;
                        end
                    end
                    ST_COLLECT:
                    begin
                        if (w_bad || (w_mark != expect_mark))
                            st_q <= ST_HUNT;
                        else if (last_pos)
                        begin
                            done_q <= 1'b1;
                            idx_q <= '0;
                            unit_q <= '0;
                        end
                        else
                        begin
                            idx_q <= idx_q + 1'b1;
                            unit_q <= (unit_q == 4'h9) ? 4'h0
                                : unit_q + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            bits_q <= '0;
        else if (code_fall && st_q == ST_COLLECT)
            bits_q[idx_q] <= w_one;
    end

    // ********************************************************
    // Field extraction and checks.
    // ********************************************************
    wire [3:0] sec_u = bits_q[tcr_pkg::P_SEC +: 4];
    wire [2:0] sec_t = bits_q[tcr_pkg::P_SEC + 5 +: 3];
    wire [3:0] min_u = bits_q[tcr_pkg::P_MIN +: 4];
    wire [2:0] min_t = bits_q[tcr_pkg::P_MIN + 5 +: 3];
    wire [3:0] hr_u = bits_q[tcr_pkg::P_HOUR +: 4];
    wire [1:0] hr_t = bits_q[tcr_pkg::P_HOUR + 5 +: 2];
    wire [3:0] day_u = bits_q[tcr_pkg::P_DAY +: 4];
    wire [3:0] day_t = bits_q[tcr_pkg::P_DAY + 5 +: 4];
    wire [1:0] day_h = bits_q[tcr_pkg::P_DAY + 10 +: 2];
    wire [3:0] yr_u = bits_q[tcr_pkg::P_YEAR +: 4];
    wire [3:0] yr_t = bits_q[tcr_pkg::P_YEAR + 5 +: 4];
    wire [4:0] hr_bin = 5'({hr_t, 3'b000}) + 5'({hr_t, 1'b0})
        + 5'(hr_u);
    wire fields_ok = (sec_u <= 4'h9) && (sec_t <= 3'h5)
        && (min_u <= 4'h9) && (min_t <= 3'h5) && (hr_u <= 4'h9)
        && (hr_bin < 5'd24) && (day_u <= 4'h9) && (day_t <= 4'h9)
        && (yr_u <= 4'h9) && (yr_t <= 4'h9);
    wire good_frame = done_q && fields_ok;

    wire yr_p = |{yr_t, yr_u};
    wire cf_p = |bits_q[tcr_pkg::P_CF_END:tcr_pkg::P_CF];
    wire sbs_p = |bits_q[tcr_pkg::P_SBS_END:tcr_pkg::P_SBS];
    wire [1:0] var_lo = (cf_p && sbs_p) ? 2'd0 : cf_p ? 2'd1
        : sbs_p ? 2'd3 : 2'd2;
    wire [2:0] var_now = {yr_p, var_lo};
    wire parity_ok = (^bits_q[tcr_pkg::P_PARITY-1:1])
        == bits_q[tcr_pkg::P_PARITY];
    wire ext_ok = cf_p && parity_ok;

    // ********************************************************
    // Configuration registers.
    // ********************************************************
    tcr_pkg::tcr_ctrl_s ctrl_q;
    logic [7:0] year_q;
    wire wr = psel && penable && pwrite;
    wire wr_ctrl = wr && (paddr == tcr_pkg::ADDR_CTRL);
    wire wr_year = wr && (paddr == tcr_pkg::ADDR_YEAR);
    wire [2:0] wd_prio = pwdata[tcr_pkg::F_PRIO +: 3];
    wire [11:0] wd_tmo = pwdata[tcr_pkg::F_TMO +: 12];
    wire prio_ok = (wd_prio != 3'h0) && (wd_prio <= tcr_pkg::PRIO_MAX);
    wire tmo_ok = (wd_tmo != 12'h000) && (wd_tmo <= tcr_pkg::TMO_MAX);

    // Out-of-range priority or timeout writes leave the old value,
    // so software can never park the block in an undefined setting.
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            ctrl_q.enable <= 1'b0;
            ctrl_q.conv <= tcr_pkg::CONV_UTC;
            ctrl_q.prio <= tcr_pkg::PRIO_RST;
            ctrl_q.dst <= 1'b0;
            ctrl_q.tz <= '0;
            ctrl_q.timeout <= tcr_pkg::TMO_RST;
            year_q <= tcr_pkg::YEAR_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q.enable <= pwdata[tcr_pkg::F_EN];
                ctrl_q.conv <= tcr_pkg::tcr_conv_e'(
                    pwdata[tcr_pkg::F_CONV +: 2]);
                ctrl_q.dst <= pwdata[tcr_pkg::F_DST];
                ctrl_q.tz <= pwdata[tcr_pkg::F_TZ +: 5];
                if (prio_ok)
                    ctrl_q.prio <= wd_prio;
                if (tmo_ok)
                    ctrl_q.timeout <= wd_tmo;
            end
            if (wr_year)
                year_q <= pwdata[7:0];
        end
    end

    // ********************************************************
    // Time convention handling.
    // ********************************************************
    wire signed [6:0] tz_s = 7'(ctrl_q.tz);
    wire signed [6:0] dst_s = {6'h00, ctrl_q.dst};
    wire signed [6:0] foff_m = {3'h0,
        bits_q[tcr_pkg::P_OFF +: 4]};
    wire signed [6:0] foff_s = bits_q[tcr_pkg::P_OFF_SIGN]
        ? -foff_m : foff_m;
    wire is_utc = (ctrl_q.conv == tcr_pkg::CONV_UTC);
    wire is_std = (ctrl_q.conv == tcr_pkg::CONV_LOCAL_STD);
    wire is_dst = (ctrl_q.conv == tcr_pkg::CONV_LOCAL_DST);
    wire signed [6:0] utc_adj = is_utc ? 7'sd0
        : is_std ? -tz_s
        : is_dst ? -(tz_s + dst_s)
        : foff_s;
    wire signed [6:0] loc_adj = is_utc ? tz_s + dst_s
        : is_std ? dst_s
        : 7'sd0;
    wire signed [6:0] hr_s = {2'b00, hr_bin};

    function automatic logic [4:0] wrap24(input logic signed [6:0] h);
        logic signed [6:0] r;
        r = h;
        if (r < 0)
            r = r + 7'sd24;
        else if (r >= 7'sd24)
            r = r - 7'sd24;
        return r[4:0];
    endfunction

    wire [4:0] utc_now = wrap24(hr_s + utc_adj);
    wire [4:0] loc_now = wrap24(hr_s + loc_adj);
    wire [7:0] year_now = var_now[2] ? {yr_t, yr_u} : year_q;

    // ********************************************************
    // Supervision, lock and time output.
    // ********************************************************
    logic have_q, ext_dst_q;
    logic [11:0] loss_q;

    // A good frame restarts the timer in the same cycle a second
    // would have counted it up, so no frame is ever missed.
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            have_q <= 1'b0;
            loss_q <= '0;
        end
        else if (good_frame)
        begin
            have_q <= 1'b1;
            loss_q <= '0;
        end
        else if (sec_tick && loss_q != 12'hFFF)
            loss_q <= loss_q + 1'b1;
    end

    assign frame_decoded_flag = have_q
        && (loss_q < ctrl_q.timeout);
    assign sync_enabled = ctrl_q.enable;
    assign locked = ctrl_q.enable && frame_decoded_flag
        && ((other_prio == 3'h0)
        || (ctrl_q.prio < other_prio));

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            variant_received <= '0;
            extended_format_compliant <= 1'b0;
            ext_dst_q <= 1'b0;
            time_out <= '0;
            utc_hour <= '0;
            local_hour <= '0;
            sync_pulse <= 1'b0;
        end
        else
        begin
            // The pulse marks the second boundary the device
            // disciplines to; the server keeps it aligned.
            sync_pulse <= pps_rise && locked;
            if (good_frame)
            begin
                variant_received <= var_now;
                extended_format_compliant <= ext_ok;
                ext_dst_q <= bits_q[tcr_pkg::P_DST];
            end
            if (good_frame && ctrl_q.enable)
            begin
                time_out.sec <= {1'b0, sec_t, sec_u};
                time_out.min <= {1'b0, min_t, min_u};
                time_out.hour <= {2'b00, hr_t, hr_u};
                time_out.day <= {2'b00, day_h, day_t, day_u};
                time_out.year <= year_now;
                utc_hour <= utc_now;
                local_hour <= loc_now;
            end
        end
    end

    // ********************************************************
    // APB read side.
    // ********************************************************
    wire setup = psel && !penable;
    wire hit = (paddr == tcr_pkg::ADDR_CTRL)
        || (paddr == tcr_pkg::ADDR_YEAR)
        || (paddr == tcr_pkg::ADDR_STATUS)
        || (paddr == tcr_pkg::ADDR_TIME)
        || (paddr == tcr_pkg::ADDR_HOURS)
        || (paddr == tcr_pkg::ADDR_LOSS);
    wire [31:0] rd_ctrl = {4'h0, ctrl_q.timeout, 3'h0, ctrl_q.tz,
        ctrl_q.dst, ctrl_q.prio, 1'b0, ctrl_q.conv, ctrl_q.enable};
    wire [31:0] rd_stat = {23'h0, ext_dst_q, variant_received,
        extended_format_compliant, locked, frame_decoded_flag,
        code_present_flag, sync_enabled};
    wire [31:0] rd_time = {time_out.year, time_out.hour,
        time_out.min, time_out.sec};
    wire [31:0] rd_hours = {3'h0, local_hour, 3'h0, utc_hour,
        4'h0, time_out.day};
    wire [31:0] rd_mux =
        (paddr == tcr_pkg::ADDR_CTRL) ? rd_ctrl
        : (paddr == tcr_pkg::ADDR_YEAR) ? {24'h0, year_q}
        : (paddr == tcr_pkg::ADDR_STATUS) ? rd_stat
        : (paddr == tcr_pkg::ADDR_TIME) ? rd_time
        : (paddr == tcr_pkg::ADDR_HOURS) ? rd_hours
        : (paddr == tcr_pkg::ADDR_LOSS) ? {20'h0, loss_q}
        : 32'h0000_0000;

    // Read data is captured in the setup cycle, so the access phase
    // completes at once without a wait state.
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !hit;
        end
    end

    assign pready = 1'b1;
endmodule
`default_nettype wire

// ===== tb/tcr_receiver_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_receiver_sva (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // APB.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Line and status.
    input wire logic pps_in,
    input wire logic [2:0] other_prio,
    input wire logic frame_decoded_flag,
    input wire logic sync_enabled,
    input wire logic locked,
    input wire logic sync_pulse,
    input wire tcr_pkg::tcr_time_s time_out,
    input wire logic [4:0] utc_hour,
    input wire logic [4:0] local_hour
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    wire logic access = psel && penable;
    wire logic mapped = paddr[1:0] == 2'b00 && paddr <= 8'h14;
    wire logic ctrl_wr = access && pwrite && paddr == tcr_pkg::ADDR_CTRL;

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_error: assert property (access && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    a_mapped_clean: assert property (access && mapped |-> !pslverr)
        else $error("error on mapped access");
    a_error_zero: assert property (access && pslverr |-> prdata == '0)
        else $error("read data not zero on error");
    a_enable_write: assert property (
        ctrl_wr |=> sync_enabled == $past(pwdata[0]))
        else $error("enable status does not follow write");
    a_locked_cause: assert property (
        locked |-> sync_enabled && frame_decoded_flag && other_prio != 3'h1)
        else $error("locked without its conditions");
    a_pulse_single: assert property (sync_pulse |=> !sync_pulse)
        else $error("sync pulse longer than one cycle");
    a_pulse_cause: assert property (
        sync_pulse |-> $past(pps_in, 3) && sync_enabled)
        else $error("sync pulse without second pulse");
    a_time_gated: assert property ($changed(time_out) |-> sync_enabled)
        else $error("time changed while disabled");
    a_hour_range: assert property (
        utc_hour < 5'd24 && local_hour < 5'd24)
        else $error("hour out of range");

    cover property ($rose(frame_decoded_flag));
    cover property ($fell(frame_decoded_flag));
    cover property (sync_pulse);
    cover property (access && pslverr);
endmodule
bind tcr_receiver tcr_receiver_sva i_sva (.clk_sys(clk_sys), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pps_in(pps_in), .other_prio(other_prio), .locked(locked),
    .frame_decoded_flag(frame_decoded_flag), .sync_enabled(sync_enabled),
    .sync_pulse(sync_pulse), .time_out(time_out), .utc_hour(utc_hour),
    .local_hour(local_hour));
`default_nettype wire

// ===== tb/tcr_server.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_server #(
    parameter int TICK_NS = 50
) (
    // Demodulated code line and second pulse.
    output logic code_in,
    output logic pps_in
);
    // The line idles low between frames, as a driven demodulator does.
    initial
    begin
        code_in = 1'b0;
        pps_in = 1'b0;
    end
    task automatic sym(input int w, input logic pps);
        code_in = 1'b1;
        pps_in = pps;
        #(w * TICK_NS);
        code_in = 1'b0;
        pps_in = 1'b0;
        #((100 - w) * TICK_NS);
    endtask
    task automatic send_frame(input logic [99:0] bits);
        for (int p = 0; p < 100; p++)
            sym((p % 10 == 9 || p == 0) ? 80 : (bits[p] ? 50 : 20), p == 0);
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("mismatch %s expected %h seen %h", nm, e, g); \
        end \
    end
`define WAIT(c, lim) \
    for (n = 0; n < lim && !(c); n++) @(posedge clk_sys); \
    if (n >= lim) fail_wait();
module testbench;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [2:0] other_prio = 3'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic code_in;
    logic pps_in;
    logic code_present_flag;
    logic frame_decoded_flag;
    logic [2:0] variant_received;
    logic extended_format_compliant;
    logic sync_enabled;
    logic locked;
    logic sync_pulse;
    tcr_pkg::tcr_time_s time_out;
    logic [4:0] utc_hour;
    logic [4:0] local_hour;
    int checks = 0;
    int miscompares = 0;
    int n;
    logic [31:0] rd;
    logic err;
    int pulses;

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // A shortened tick keeps one frame at 20000 clocks.
    tcr_receiver #(.TICK_CYC(2)) i_dut (.clk_sys(clk_sys), .rstn(rstn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .code_in(code_in), .pps_in(pps_in),
        .other_prio(other_prio), .code_present_flag(code_present_flag),
        .frame_decoded_flag(frame_decoded_flag),
        .variant_received(variant_received),
        .extended_format_compliant(extended_format_compliant),
        .sync_enabled(sync_enabled), .locked(locked),
        .sync_pulse(sync_pulse), .time_out(time_out),
        .utc_hour(utc_hour), .local_hour(local_hour));
    tcr_server #(.TICK_NS(50)) i_srv (.code_in(code_in), .pps_in(pps_in));
    always @(posedge clk_sys) pulses += (sync_pulse === 1'b1);

    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic fail_wait();
        miscompares++;
        complete_run();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        `WAIT(pready === 1'b1, 50)
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // ********************************************************
    // Scenarios.
    // ********************************************************
    task automatic regs_after_reset();
        apb(1'b0, tcr_pkg::ADDR_CTRL, '0, rd, err);
        `CHK("ctrl reset", 32'h0014_0010, rd)
        apb(1'b0, tcr_pkg::ADDR_STATUS, '0, rd, err);
        `CHK("status reset", 32'h0000_0000, rd)
        apb(1'b0, 8'h18, '0, rd, err);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
    endtask
    task automatic ctrl_writes();
        logic [31:0] wv[4] = '{32'h0000_0101, 32'h0E10_0111,
            32'h0E11_0161, 32'h0002_0111};
        logic [31:0] ev[4] = '{32'h0014_0111, 32'h0E10_0111,
            32'h0E10_0111, 32'h0002_0111};
        logic [31:0] w;
        for (int i = 0; i < 8; i++)
        begin
            w = (i < 4) ? wv[i] : 32'h0002_0111 | 32'((7 - i) << 1);
            apb(1'b1, tcr_pkg::ADDR_CTRL, w, rd, err);
            apb(1'b0, tcr_pkg::ADDR_CTRL, '0, rd, err);
            `CHK("ctrl readback", (i < 4) ? ev[i] : w, rd)
        end
        `CHK("sync enabled", 1'b1, sync_enabled)
    endtask
    task automatic frames_and_loss();
        logic [99:0] f1 = (100'd1 << 25) | (100'd1 << 50) |
            (100'd1 << 51) | (100'd1 << 56);
        logic [99:0] f3 = (100'd1 << 25) | (100'd1 << 65);
        fork
            begin
                #7;
                i_srv.sym(80, 1'b0);
                i_srv.send_frame(f1);
                i_srv.send_frame(f1 | 100'd2);
            end
        join_none
        `WAIT(frame_decoded_flag === 1'b1, 25000)
        @(posedge clk_sys);
        `CHK("present", 1'b1, code_present_flag)
        `CHK("variant", 3'd6, variant_received)
        `CHK("compliant", 1'b0, extended_format_compliant)
        `CHK("year", 8'h23, time_out.year)
        `CHK("hour", 8'h10, time_out.hour)
        `CHK("utc hour", 5'd10, utc_hour)
        `CHK("local hour", 5'd11, local_hour)
        `CHK("locked", 1'b1, locked)
        other_prio <= 3'd2;
        @(posedge clk_sys);
        `CHK("locked above", 1'b1, locked)
        other_prio <= 3'd1;
        @(posedge clk_sys);
        `CHK("locked tie", 1'b0, locked)
        other_prio <= 3'd0;
        apb(1'b1, tcr_pkg::ADDR_CTRL, 32'h0002_0195, rd, err);
        `WAIT(time_out.sec === 8'h01, 25000)
        @(posedge clk_sys);
        `CHK("utc hour dst", 5'd8, utc_hour)
        `CHK("local hour dst", 5'd10, local_hour)
        apb(1'b1, tcr_pkg::ADDR_CTRL, 32'h0001_0197, rd, err);
        `WAIT(frame_decoded_flag === 1'b0, 30000)
        `CHK("locked lost", 1'b0, locked)
        `WAIT(code_present_flag === 1'b0, 1000)
        apb(1'b1, tcr_pkg::ADDR_YEAR, 32'h0000_0024, rd, err);
        fork
            begin
                #7;
                i_srv.sym(80, 1'b0);
                i_srv.send_frame(f3);
            end
        join_none
        `WAIT(frame_decoded_flag === 1'b1, 25000)
        `CHK("year2", 8'h24, time_out.year)
        `CHK("variant2", 3'd1, variant_received)
        `CHK("compliant2", 1'b1, extended_format_compliant)
        `CHK("utc hour ext", 5'd11, utc_hour)
        `CHK("local hour ext", 5'd10, local_hour)
        `CHK("sync pulses", 1, pulses)
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        regs_after_reset();
        ctrl_writes();
        frames_and_loss();
        complete_run();
    end
endmodule
`default_nettype wire
